// ===== pkg/lb_cfg.svh
// Offsets, field positions, reset values and counts of the logic block
`ifndef LB_CFG_SVH
`define LB_CFG_SVH
`define MC_NUM        16
`define PT_PER_MC     5
`define PT_NUM        80
`define SW_NUM        40
`define FB_NUM        128
`define GPIN_NUM      84
`define GBUS_PAD      44
`define ARR_W         56
`define CHAIN_LEN     8
`define TERM_WORDS    320
`define PINB_W        108
`define PINB_HELD     106
`define SLEEP_MC_ONE  3
`define SLEEP_MC_TWO  11
`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_SW_BASE   12'h100
`define OFF_SW_END    12'h1A0
`define OFF_MODE_BASE 12'h200
`define OFF_MODE_END  12'h280
`define OFF_TERM_BASE 12'h400
`define OFF_TERM_END  12'h900
`define CTRL_PD_EN    0
`define STATUS_PD     0
`define STATUS_Q_LSB  16
`define RST_CTRL      32'h0000_0000
`define RST_MODE      32'h0000_0000
`define RST_TSEL      32'h0000_0000
`define RST_TERM      32'h0000_0000
`define RST_SW        8'h00
`endif

// ===== pkg/lb_pkg.sv
// Types shared by the logic block: modes, selects and the pin bundle
package lb_pkg;
   typedef enum logic [2:0] {ff_d, ff_t, ff_jk, ff_sr, ff_latch} ff_mode_t;
   typedef enum logic [1:0] {xor_low, xor_high, xor_term} xor_src_t;
   typedef enum logic [1:0] {d_xor, d_term, d_pin} d_src_t;
   typedef enum logic [1:0] {clr_off, clr_global, clr_term, clr_both}
      clr_src_t;
   typedef enum logic [2:0] {oe_off, oe_on, oe_pin_a, oe_pin_a_n,
      oe_pin_b, oe_pin_b_n, oe_io_pin, oe_cell} oe_src_t;
   // Mode word of one macrocell
   typedef struct packed {
      logic [7:0] spare;
      logic       fb_reg;
      logic       out_reg;
      oe_src_t    oe_sel;
      logic       ap_en;
      clr_src_t   ar_sel;
      logic       ce_en;
      logic [1:0] clk_sel;
      ff_mode_t   ff_mode;
      d_src_t     d_sel;
      xor_src_t   xor_sel;
      logic       casc_en;
      logic [4:0] or_mask;
   } mc_mode_t;
   // term_allocation_select: which of the five terms feeds each use, except oe_pt, which picks an I/O pin or a cell
   typedef struct packed {
      logic [4:0] spare;
      logic [2:0] k_pt;
      logic [2:0] oe_pt;
      logic [2:0] fold_pt;
      logic [2:0] ap_pt;
      logic [2:0] ar_pt;
      logic [2:0] ce_pt;
      logic [2:0] clk_pt;
      logic [2:0] d_pt;
      logic [2:0] xor_pt;
   } term_sel_t;
   // Filtered pin inputs
   typedef struct packed {
      logic        sleep_two;
      logic        sleep_one;
      logic [1:0]  oe_pins;
      logic        clear;
      logic [2:0]  clk;
      logic [15:0] io;
      logic [83:0] gp;
   } pin_bundle_t;
endpackage

// ===== src/lb_macro_block.sv
// Logic block of sixteen macrocells with power-down and APB setup
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lb_cfg.svh"
// Function
// - five product terms, all array inputs each
// - global bus of pins and feedback, pick 40
// - OR five terms, cascade up to forty
// - one cascade chain of forty terms, cells 0 to 7
// - XOR second input term, high or low
// - data from XOR, own term or pin
// - storage as D, T, JK, SR or latch
// - latch passes while clock high, holds low
// - clock from three globals or term, rising
// - term clock enable low ignores edges of a global clock
// - clear from global, term, both or off
// - set from a term or off
// - pin and feedback each registered or combinatorial
// - pin direction and output enable selection
// - inverted term folded back to regional bus
// - sleep pin high enters power-down when enabled
// - power-down freezes logic and enabled outputs
// - pin changes ignored until sleep pin low
// - sleep pin cells lose pin logic only
module pld_macrocell_with_powerdown (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [11:0]   paddr,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   input  wire logic [83:0]   pin_in,
   input  wire logic [15:0]   io_in,
   input  wire logic [2:0]    global_clk_line,
   input  wire logic          global_clear_line,
   input  wire logic [1:0]    oe_pin,
   input  wire logic          sleep_pin_one,
   input  wire logic          sleep_pin_two,
   input  wire logic [127:0]  fb_in,
   output logic [15:0]        pin_out,
   output logic [15:0]        pin_oe,
   output logic [15:0]        fb_out,
   output logic               powered_down
);

   // Every check runs on the bus clock and rests during reset
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ***************************************************
   // Helpers
   // ***************************************************

   // One product term: AND of selected true and complement inputs
   function automatic logic term_eval(input logic [55:0] v,
                                      input logic [55:0] t,
                                      input logic [55:0] c);
      return (&(~t | v)) & (&(~c | ~v));
   endfunction

   // Pick one of a macrocell's five terms; codes above four read low
   function automatic logic pick(input logic [4:0] t,
                                 input logic [2:0] i);
      return (i < 3'h5) ? t[i] : 1'b0;
   endfunction

   // Next value of the storage element
   function automatic logic ff_next(input lb_pkg::ff_mode_t md,
                                    input logic q, input logic d,
                                    input logic k, input logic lvl,
                                    input logic fire);
      logic r;
      r = q;
      if (md == lb_pkg::ff_latch) begin
         r = lvl ? d : q;
      end else if (fire) begin
         case (md)
            lb_pkg::ff_d: r = d;
            lb_pkg::ff_t: r = q ^ d;
            lb_pkg::ff_jk: r = d ? (k ? ~q : 1'b1) : (k ? 1'b0 : q);
            lb_pkg::ff_sr: r = (d & ~k) ? 1'b1 : ((k & ~d) ? 1'b0 : q);
            default: r = q;
         endcase
      end
      return r;
   endfunction

   // ***************************************************
   // Configuration storage
   // ***************************************************

   logic [31:0]        ctrl;                 // Power-down enable
   logic [7:0]         sw_sel [`SW_NUM];     // Switch matrix picks
   lb_pkg::mc_mode_t   mode [`MC_NUM];       // Per-cell modes
   lb_pkg::term_sel_t  tsel [`MC_NUM];       // Per-cell term use
   logic [31:0]        term_mem [`TERM_WORDS]; // Term masks
   logic [15:0]        q;                    // Storage elements
   logic               pd;                   // Power-down active

   // ***************************************************
   // APB slave
   // ***************************************************

   wire        acc     = psel & penable;
   wire        wr      = acc & pwrite;
   wire        setup   = psel & ~penable;
   wire        aligned = (paddr[1:0] == 2'h0);
   wire [11:0] sw_off  = paddr - `OFF_SW_BASE;
   wire [11:0] md_off  = paddr - `OFF_MODE_BASE;
   wire [11:0] tm_off  = paddr - `OFF_TERM_BASE;
   wire [5:0]  sw_idx  = sw_off[7:2];
   wire [3:0]  md_idx  = md_off[6:3];
   wire        md_word = md_off[2];
   wire [8:0]  tm_idx  = tm_off[10:2];
   wire hit_ctrl = aligned & (paddr == `OFF_CTRL);
   wire hit_stat = aligned & (paddr == `OFF_STATUS);
   wire hit_sw   = aligned & (paddr >= `OFF_SW_BASE)
                 & (paddr < `OFF_SW_END);
   wire hit_mode = aligned & (paddr >= `OFF_MODE_BASE)
                 & (paddr < `OFF_MODE_END);
   wire hit_term = aligned & (paddr >= `OFF_TERM_BASE)
                 & (paddr < `OFF_TERM_END);
   wire hit = hit_ctrl | hit_stat | hit_sw | hit_mode | hit_term;

   // Status shows power-down and every storage element
   wire [31:0] status = {q, 15'h0000, pd};
   wire [31:0] mode_rd = md_word ? tsel[md_idx] : mode[md_idx];
   wire [31:0] rd_mux  = hit_ctrl ? ctrl
                       : hit_stat ? status
                       : hit_sw   ? {24'h00_0000, sw_sel[sw_idx]}
                       : hit_mode ? mode_rd
                       : hit_term ? term_mem[tm_idx]
                       : 32'h0000_0000;

   // Zero wait states; errors only on unmapped or unaligned access
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;

   // Read data captured in the setup cycle so it leaves a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup & ~pwrite) begin
         prdata <= rd_mux;
      end
   end

   // Register writes land at the access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `RST_CTRL;
         for (int i = 0; i < `SW_NUM; i++) sw_sel[i] <= `RST_SW;
         for (int i = 0; i < `MC_NUM; i++) begin
            mode[i] <= `RST_MODE;
            tsel[i] <= `RST_TSEL;
         end
         for (int i = 0; i < `TERM_WORDS; i++) term_mem[i] <= `RST_TERM;
      end else if (wr) begin
         if (hit_ctrl) ctrl <= pwdata;
         if (hit_sw) sw_sel[sw_idx] <= pwdata[7:0];
         if (hit_mode & ~md_word) mode[md_idx] <= pwdata;
         if (hit_mode & md_word) tsel[md_idx] <= pwdata;
         if (hit_term) term_mem[tm_idx] <= pwdata;
      end
   end

   // ***************************************************
   // Pin input filter and power-down
   // ***************************************************

   logic [`PINB_W-1:0] s1, s2, s3, filt;   // Three-stage synchroniser
   lb_pkg::pin_bundle_t pf;                // Filtered view
   wire [`PINB_W-1:0] raw = {sleep_pin_two, sleep_pin_one, oe_pin,
                     global_clear_line, global_clk_line, io_in, pin_in};
   // Sleep pins keep tracking; all others freeze while powered down
   wire [`PINB_W-1:0] track = {2'b11, {`PINB_HELD{~pd}}};
   wire [`PINB_W-1:0] upd   = ~(s2 ^ s3) & track;
   assign pf = filt;

   // A change counts only when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         filt <= '0;
      end else begin
         s1   <= raw;
         s2   <= s1;
         s3   <= s2;
         filt <= (filt & ~upd) | (s3 & upd);
      end
   end

   // Either sleep pin enters power-down once the option is on
   assign pd = ctrl[`CTRL_PD_EN] & (pf.sleep_one | pf.sleep_two);
   assign powered_down = pd;

   // Cells whose pins serve as sleep inputs lose pin logic only
   wire [15:0] owned = ctrl[`CTRL_PD_EN]
      ? ((16'h0001 << `SLEEP_MC_ONE) | (16'h0001 << `SLEEP_MC_TWO))
      : 16'h0000;

   // ***************************************************
   // Global bus, switch matrix, product terms
   // ***************************************************

   logic [15:0] fold_q;   // Registered foldback breaks the term loop
   wire [255:0] gbus = {{`GBUS_PAD{1'b0}}, fb_in, pf.gp};
   wire [39:0]  sw;
   wire [55:0]  arr_in = {fold_q, sw};
   wire [79:0]  pt;

   // Each of the forty switch outputs picks one global bus line
   genvar k;
   generate
      for (k = 0; k < `SW_NUM; k++) begin : g_sw
         assign sw[k] = gbus[sw_sel[k]];
      end
      for (k = 0; k < `PT_NUM; k++) begin : g_pt
         assign pt[k] = term_eval(arr_in,
            {term_mem[4*k+1][23:0], term_mem[4*k]},
            {term_mem[4*k+3][23:0], term_mem[4*k+2]});
      end
   endgenerate

   // ***************************************************
   // Macrocells
   // ***************************************************

   logic [15:0] clk_prev;           // Last seen level of each clock
   wire  [15:0] sum, comb, dv, kv, lvl, edg, ce, clr, set;
   wire  [15:0] next_q, oe_next, cas;

   genvar m;
   generate
      for (m = 0; m < `MC_NUM; m++) begin : g_mc
         wire [4:0] t = pt[m*`PT_PER_MC +: `PT_PER_MC];
         lb_pkg::mc_mode_t  md;
         lb_pkg::term_sel_t ts;
         logic xin;
         assign md = mode[m];
         assign ts = tsel[m];

         // One chain per block, eight cells long: forty terms at most
         if (m == 0 || m >= `CHAIN_LEN) begin : g_head
            assign cas[m] = 1'b0;
         end else begin : g_link
            assign cas[m] = sum[m-1];
         end

         // OR of selected terms plus the cascade from the neighbour
         assign sum[m] = (|(t & md.or_mask))
                       | (md.casc_en & cas[m]);

         // Second XOR input sets polarity or adds a term
         assign xin = (md.xor_sel == lb_pkg::xor_high) ? 1'b1
            : (md.xor_sel == lb_pkg::xor_term) ? pick(t, ts.xor_pt)
            : 1'b0;
         assign comb[m] = sum[m] ^ xin;

         // Data source; sleep-owned pins give no logic input
         assign dv[m] = (md.d_sel == lb_pkg::d_term) ? pick(t, ts.d_pt)
            : (md.d_sel == lb_pkg::d_pin) ? (pf.io[m] & ~owned[m])
            : comb[m];
         assign kv[m] = pick(t, ts.k_pt);

         // Clock: global line or own term, acting on rising edge
         assign lvl[m] = (md.clk_sel == 2'h3) ? pick(t, ts.clk_pt)
                       : pf.clk[md.clk_sel];
         assign edg[m] = lvl[m] & ~clk_prev[m];
         // Enable applies only with a global clock
         assign ce[m] = (md.ce_en && md.clk_sel != 2'h3)
                      ? pick(t, ts.ce_pt) : 1'b1;

         // Clear and set sources
         assign clr[m] = (md.ar_sel == lb_pkg::clr_global) ? pf.clear
            : (md.ar_sel == lb_pkg::clr_term) ? pick(t, ts.ar_pt)
            : (md.ar_sel == lb_pkg::clr_both)
               ? (pf.clear | pick(t, ts.ar_pt))
            : 1'b0;
         assign set[m] = md.ap_en & pick(t, ts.ap_pt);

         // Clear beats set, both beat the clock
         assign next_q[m] = clr[m] ? 1'b0
            : set[m] ? 1'b1
            : ff_next(md.ff_mode, q[m], dv[m], kv[m], lvl[m],
                      edg[m] & ce[m]);

         // Output enable selection, dropped for sleep-owned pins
         assign oe_next[m] = ~owned[m] & (
              (md.oe_sel == lb_pkg::oe_on)     ? 1'b1
            : (md.oe_sel == lb_pkg::oe_pin_a)  ? pf.oe_pins[0]
            : (md.oe_sel == lb_pkg::oe_pin_a_n) ? ~pf.oe_pins[0]
            : (md.oe_sel == lb_pkg::oe_pin_b)  ? pf.oe_pins[1]
            : (md.oe_sel == lb_pkg::oe_pin_b_n) ? ~pf.oe_pins[1]
            : (md.oe_sel == lb_pkg::oe_io_pin) ? pf.io[ts.oe_pt]
            : (md.oe_sel == lb_pkg::oe_cell)   ? q[ts.oe_pt]
            : 1'b0);

         // Everything in the cell freezes while powered down
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               q[m]        <= 1'b0;
               clk_prev[m] <= 1'b0;
               fold_q[m]   <= 1'b0;
               pin_out[m]  <= 1'b0;
               pin_oe[m]   <= 1'b0;
               fb_out[m]   <= 1'b0;
            end else if (!pd) begin
               q[m]        <= next_q[m];
               clk_prev[m] <= lvl[m];
               fold_q[m]   <= ~pick(t, ts.fold_pt);
               pin_out[m]  <= md.out_reg ? next_q[m] : comb[m];
               pin_oe[m]   <= oe_next[m];
               fb_out[m]   <= md.fb_reg ? next_q[m] : comb[m];
            end
         end

         // Clear wins whenever it is active outside power-down
         a_clear_wins: assert property (
            !pd && clr[m] |=> !q[m])
            else $error("clear did not force the cell low");
         // A low enable makes the edge ignored
         a_enable_blocks: assert property (
            !pd && edg[m] && !ce[m] && !clr[m] && !set[m]
            && md.ff_mode != lb_pkg::ff_latch
            |=> $stable(q[m]))
            else $error("edge taken with enable low");
         // Latch follows data while the clock is high
         a_latch_pass: assert property (
            !pd && md.ff_mode == lb_pkg::ff_latch && lvl[m]
            && !clr[m] && !set[m]
            |=> q[m] == $past(dv[m]))
            else $error("latch did not pass data");
         // D mode takes data on an enabled rising edge
         a_edge_load: assert property (
            !pd && md.ff_mode == lb_pkg::ff_d && edg[m] && ce[m]
            && !clr[m] && !set[m]
            |=> q[m] == $past(dv[m]))
            else $error("D element missed its edge");
      end
   endgenerate

   // ***************************************************
   // Block-level checks
   // ***************************************************

   // A write to control lands at the access edge
   a_ctrl_write: assert property (
      wr && hit_ctrl |=> ctrl == $past(pwdata))
      else $error("control write lost");
   // A held sleep pin reaches power-down through the filter
   a_sleep_entry: assert property (
      (ctrl[`CTRL_PD_EN] && sleep_pin_one) [*5] |-> pd)
      else $error("sleep pin did not power down");
   // Cell state and pins hold while powered down
   a_freeze_hold: assert property (
      pd && $past(pd) |-> $stable(q) && $stable(pin_out)
      && $stable(pin_oe))
      else $error("state moved during power-down");
   // Filtered pins other than the sleep pins stand still
   a_pins_ignored: assert property (
      pd && $past(pd) |-> $stable(filt[`PINB_HELD-1:0]))
      else $error("pin change seen during power-down");
   // Sleep-owned pins never drive
   a_sleep_no_drive: assert property (
      ctrl[`CTRL_PD_EN] && !pd |=> !pin_oe[`SLEEP_MC_ONE]
      && !pin_oe[`SLEEP_MC_TWO])
      else $error("sleep pin driven as output");

endmodule
`default_nettype wire

// ===== testbench/lb_pin_model.sv
// Partner model: global clock pins and feedback of neighbouring cells
`timescale 1ns/1ps
`default_nettype none
module lb_pin_model (
   input  wire logic    pclk,
   input  wire logic    presetn,
   input  wire logic    clk_go,
   output logic         clk_busy,
   output logic [2:0]   global_clk_line,
   output logic [127:0] fb_in
);
   // ****************************
   // Clock pulse and feedback
   // ****************************
   logic [3:0] phase;   // Position inside one pulse
   // One pulse on line 0: eight cycles high, then eight low, so the
   // sampled clock always meets its minimum high and low times
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_busy <= 1'b0;
         phase    <= 4'h0;
      end else if (clk_go && !clk_busy) begin
         clk_busy <= 1'b1;
         phase    <= 4'h0;
      end else if (clk_busy) begin
         phase    <= phase + 4'h1;
         clk_busy <= (phase != 4'hf);
      end
   end
   // Rising edge of the pulse is what the cell loads on
   assign global_clk_line = {2'b00, clk_busy & ~phase[3]};
   // Neighbour feedback never sits still, so stale values cannot match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_in <= '0;
      end else begin
         fb_in <= {fb_in[126:0], ~fb_in[127]};
      end
   end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the macrocell logic block
`timescale 1ns/1ps
`default_nettype none
`include "lb_cfg.svh"
module tb;
   // ********
   // Signals
   // ********
   logic         pclk = 1'b0;            // Bus clock
   logic         presetn = 1'b0;         // Reset, active low
   logic [11:0]  paddr = 12'h000;        // Register address
   logic         psel = 1'b0;            // Select
   logic         penable = 1'b0;         // Access phase
   logic         pwrite = 1'b0;          // Direction
   logic [31:0]  pwdata = 32'h0000_0000; // Write data
   logic         pready;                 // Always ready
   logic [31:0]  prdata;                 // Read data
   logic         pslverr;                // Refusal flag
   logic [83:0]  pin_in = '0;            // Dedicated pins
   logic [15:0]  io_in = 16'h0000;       // I/O pins
   logic [2:0]   global_clk_line;        // From the partner
   logic         global_clear_line = 1'b0;
   logic [1:0]   oe_pin = 2'b00;         // Output enable pins
   logic         sleep_pin_one = 1'b0;   // Power-down pins
   logic         sleep_pin_two = 1'b0;
   logic [127:0] fb_in;                  // Neighbour feedback
   logic [15:0]  pin_out;                // Cell outputs
   logic [15:0]  pin_oe;
   logic [15:0]  fb_out;
   logic         powered_down;
   logic         clk_go = 1'b0;          // Pulse request to partner
   logic         clk_busy;               // Pulse in progress
   logic [31:0]  r;                      // Random word
   // Expected answer of one transfer
   typedef struct {
      logic [11:0] addr;
      logic [31:0] data;
      logic        rd;
      logic        err;
   } note_t;
   note_t        notes[$];               // Oldest note first
   note_t        nt;
   int           fails = 0;
   int           check_count = 0;
   localparam int SETTLE = 10;           // Pin filter needs four edges

   always #5 pclk = ~pclk;

   pld_macrocell_with_powerdown pld_macrocell_with_powerdown_i (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .pin_in(pin_in), .io_in(io_in), .global_clk_line(global_clk_line),
      .global_clear_line(global_clear_line), .oe_pin(oe_pin),
      .sleep_pin_one(sleep_pin_one), .sleep_pin_two(sleep_pin_two),
      .fb_in(fb_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .fb_out(fb_out), .powered_down(powered_down));

   lb_pin_model lb_pin_model_i (
      .pclk(pclk), .presetn(presetn), .clk_go(clk_go),
      .clk_busy(clk_busy), .global_clk_line(global_clk_line),
      .fb_in(fb_in));

   // *****************
   // Tasks and checks
   // *****************
   task automatic summarize();
      if (fails == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp_data(input logic [11:0] a, input logic [31:0] e,
                           input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("Error prdata at %h expected %h seen %h", a, e, g);
      end
   endtask

   task automatic cmp_flag(input logic [11:0] a, input logic e,
                           input logic g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("Error pslverr at %h expected %b seen %b", a, e, g);
      end
   endtask

   // Pin side: power-down flag, enables, pin data and feedback
   task automatic cmp_out(input logic [48:0] e);
      check_count++;
      if ({powered_down, pin_oe, pin_out, fb_out} !== e) begin
         fails++;
         $display("Error outputs expected %h seen %h", e,
                  {powered_down, pin_oe, pin_out, fb_out});
      end
   endtask

   // One transfer; holds the request until pready is seen high
   task automatic apb(input logic dir, input logic [11:0] a,
                      input logic [31:0] d, input logic [31:0] e,
                      input logic er);
      int n;
      psel   <= 1'b1;
      pwrite <= dir;
      paddr  <= a;
      pwdata <= d;
      notes.push_back('{a, e, !dir, er});
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         fails++;
         summarize();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0000_0000, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic er);
      apb(1'b0, a, 32'h0000_0000, e, er);
   endtask

   // One global clock pulse from the partner, bounded wait
   task automatic pulse();
      int n;
      clk_go <= 1'b1;
      @(posedge pclk);
      clk_go <= 1'b0;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (clk_busy !== 1'b0 && n < 100);
      if (clk_busy !== 1'b0) begin
         fails++;
         summarize();
      end
   endtask

   // Watcher: every completed access is matched with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         nt = notes.pop_front();
         if (nt.rd) cmp_data(nt.addr, nt.data, prdata);
         cmp_flag(nt.addr, nt.err, pslverr);
      end
   end

   initial begin
      void'($urandom(32'hf069));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      io_in  <= 16'($urandom());
      oe_pin <= 2'($urandom());
      r = $urandom();
      // Reset values, refusals and plain readback
      rd(`OFF_CTRL, 32'h0000_0000, 1'b0);
      rd(`OFF_STATUS, 32'h0000_0000, 1'b0);
      rd(`OFF_MODE_BASE, 32'h0000_0000, 1'b0);
      rd(12'hFFC, 32'h0000_0000, 1'b1);
      rd(12'h002, 32'h0000_0000, 1'b1);
      wr(`OFF_TERM_BASE + 12'h4F0, r);
      rd(`OFF_TERM_BASE + 12'h4F0, r, 1'b0);
      wr(`OFF_SW_BASE + 12'h004, 32'h0000_0001);
      rd(`OFF_SW_BASE + 12'h004, 32'h0000_0001, 1'b0);
      // Cell 0: data from pin 0, enable from pin 1, registered output
      wr(`OFF_TERM_BASE, 32'h0000_0001);
      wr(`OFF_TERM_BASE + 12'h010, 32'h0000_0002);
      wr(`OFF_MODE_BASE + 12'h004, 32'h0000_0200);
      wr(`OFF_MODE_BASE, 32'h0048_8001);
      pin_in <= 84'h3;
      repeat (SETTLE) @(posedge pclk);
      pulse();
      rd(`OFF_STATUS, 32'h0001_0000, 1'b0);
      cmp_out({1'b0, 16'h0001, 16'h0001, 16'h0001});
      // Enable low: the edge must be ignored
      pin_in <= 84'h0;
      repeat (SETTLE) @(posedge pclk);
      pulse();
      rd(`OFF_STATUS, 32'h0001_0000, 1'b0);
      cmp_out({1'b0, 16'h0001, 16'h0001, 16'h0000});
      // Power-down holds state and ignores pin changes
      wr(`OFF_CTRL, 32'h0000_0001);
      sleep_pin_one <= 1'b1;
      repeat (SETTLE) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0001_0001, 1'b0);
      pin_in <= 84'h2;
      repeat (SETTLE) @(posedge pclk);
      pulse();
      rd(`OFF_STATUS, 32'h0001_0001, 1'b0);
      cmp_out({1'b1, 16'h0001, 16'h0001, 16'h0000});
      sleep_pin_one <= 1'b0;
      repeat (SETTLE) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0001_0000, 1'b0);
      pulse();
      rd(`OFF_STATUS, 32'h0000_0000, 1'b0);
      cmp_out({1'b0, 16'h0001, 16'h0000, 16'h0000});
      sleep_pin_two <= 1'b1;
      repeat (SETTLE) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0000_0001, 1'b0);
      sleep_pin_two <= 1'b0;
      repeat (SETTLE) @(posedge pclk);
      // Set from an always-true term, clear from the global line
      wr(`OFF_MODE_BASE + 12'h004, 32'h0001_0200);
      wr(`OFF_MODE_BASE, 32'h004D_8001);
      repeat (4) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0001_0000, 1'b0);
      cmp_out({1'b0, 16'h0001, 16'h0001, 16'h0000});
      global_clear_line <= 1'b1;
      repeat (SETTLE) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0000_0000, 1'b0);
      global_clear_line <= 1'b0;
      repeat (SETTLE) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0001_0000, 1'b0);
      // Latch: holds while the clock is low, follows data while high
      wr(`OFF_MODE_BASE, 32'h0048_1001);
      repeat (4) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0001_0000, 1'b0);
      pulse();
      rd(`OFF_STATUS, 32'h0000_0000, 1'b0);
      pin_in <= 84'h1;
      repeat (SETTLE) @(posedge pclk);
      rd(`OFF_STATUS, 32'h0000_0000, 1'b0);
      pulse();
      rd(`OFF_STATUS, 32'h0001_0000, 1'b0);
      cmp_out({1'b0, 16'h0001, 16'h0001, 16'h0001});
      summarize();
   end
endmodule
`default_nettype wire
